// [brownout_regs.svh]
// Constants for the brownout gain manager: timing, steps and limits
`ifndef BROWNOUT_REGS_SVH
`define BROWNOUT_REGS_SVH

// =====================================================================
// Clock and timing
`define CLOCK_HZ            100000000
`define TICK_HZ             1000
`define TICK_DIV            (`CLOCK_HZ / `TICK_HZ)
`define STAB_PERIOD_S       30
`define AVG_STEP_S          10
`define NOTIFY_REPEAT_MIN   5
`define STAB_TICKS          (`STAB_PERIOD_S * `TICK_HZ)
`define AVG_STEP_TICKS      (`AVG_STEP_S * `TICK_HZ)
`define NOTIFY_TICKS        (`NOTIFY_REPEAT_MIN * 60 * `TICK_HZ)

// =====================================================================
// Gain steps and limits
`define INST_STEP_DB        4'h3
`define INST_MAX_STEPS      2'h2
`define AVG_MAX_STEPS       5'h12
`define AVG_STEP_DB         5'h01

`endif

// [brownout_pkg.sv]
// Types shared by the brownout gain manager
package brownout_pkg;

    // Comparator results from the supply monitor
    typedef struct packed {
        logic inst_below_095;
        logic inst_above_100;
        logic inst_above_110;
        logic avg_below_095;
        logic avg_above_110;
        logic low_batt;
    } supply_type;

    // Gain controls toward the audio path
    typedef struct packed {
        logic [3:0] inst_atten_db;
        logic [4:0] avg_atten_db;
        logic [5:0] total_atten_db;
        logic       mute;
    } gain_type;

    typedef enum logic [1:0] {
        INST_IDLE,
        INST_STAB,
        INST_MONITOR
    } inst_state_type;

endpackage

// [brownout_gain_manager.sv]
// Supply-driven gain reduction, mute and low-battery notification
`timescale 1ns/1ps
`include "brownout_regs.svh"

module brownout_gain_manager #(
    parameter int TICK_DIV     = `TICK_DIV,
    parameter int STAB_TICKS   = `STAB_TICKS,
    parameter int AVG_TICKS    = `AVG_STEP_TICKS,
    parameter int NOTIFY_TICKS = `NOTIFY_TICKS
) (
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    sys_rst,
    // Supply monitor comparators, asynchronous
    input  wire brownout_pkg::supply_type supply_in,
    // Restart context from the power-on logic
    input  wire logic                    deep_drop,
    input  wire logic [1:0]              prior_memory,
    input  wire logic                    notify_enable,
    // Gain path controls, start memory and low-battery request
    output brownout_pkg::gain_type       gain_out,
    output logic [1:0]                   start_memory,
    output logic                         low_batt_req
);

    // Counters are 24 bits wide; longer periods are rejected with an elaboration error
    if (TICK_DIV < 2 || STAB_TICKS < 1 || AVG_TICKS < 1 || NOTIFY_TICKS < 1
        || TICK_DIV > 32'h00FFFFFF || STAB_TICKS > 32'h00FFFFFF
        || AVG_TICKS > 32'h00FFFFFF || NOTIFY_TICKS > 32'h00FFFFFF) begin : bad_timing
        $error("brownout_gain_manager: timing parameters out of range");
    end

    // =================================================================
    // State
    typedef struct packed {
        brownout_pkg::supply_type     sync1;
        brownout_pkg::supply_type     sync2;
        logic [23:0]                  div_cnt;
        logic                         tick;
        brownout_pkg::inst_state_type inst_state;
        logic [1:0]                   inst_steps;
        logic [23:0]                  inst_cnt;
        logic                         saw_above_100;
        logic                         saw_above_110;
        logic [4:0]                   avg_steps;
        logic [23:0]                  avg_cnt;
        logic                         mute;
        logic                         notify_active;
        logic [23:0]                  notify_cnt;
        logic                         req;
        logic                         restart_done;
        logic [1:0]                   memory;
        brownout_pkg::gain_type       gain;
    } state_type;

    state_type state_q;
    state_type state_d;

    function automatic logic [23:0] bump(input logic [23:0] cnt);
        bump = cnt + 24'h000001;
    endfunction

    brownout_pkg::supply_type sup;
    assign sup = state_q.sync2;

    always_comb begin
        logic win_100;
        logic win_110;
        win_100       = 1'b0;
        win_110       = 1'b0;
        state_d       = state_q;
        state_d.sync1 = supply_in;
        state_d.sync2 = state_q.sync1;
        state_d.req   = 1'b0;
        state_d.tick  = 1'b0;

        // =============================================================
        // Slow tick divider
        if (state_q.div_cnt == 24'(TICK_DIV - 1)) begin
            state_d.div_cnt = 24'h000000;
            state_d.tick    = 1'b1;
        end else begin
            state_d.div_cnt = bump(state_q.div_cnt);
        end

        // =============================================================
        // Restart context, caught once after reset release
        if (!state_q.restart_done) begin
            state_d.restart_done = 1'b1;
            state_d.memory       = deep_drop ? 2'h0 : prior_memory;
        end

        // =============================================================
        // Instantaneous path, entered from idle only while avg_below_095 is clear
        case (state_q.inst_state)
            brownout_pkg::INST_IDLE: begin
                if (sup.inst_below_095 && !sup.avg_below_095) begin
                    state_d.inst_steps = 2'h1;
                    state_d.inst_state = brownout_pkg::INST_STAB;
                    state_d.inst_cnt   = 24'h000000;
                end
            end
            brownout_pkg::INST_STAB: begin
                // Comparator ignored while the supply settles
                if (state_q.tick) begin
                    if (state_q.inst_cnt == 24'(STAB_TICKS - 1)) begin
                        state_d.inst_state    = brownout_pkg::INST_MONITOR;
                        state_d.inst_cnt      = 24'h000000;
                        state_d.saw_above_100 = 1'b1;
                        state_d.saw_above_110 = 1'b1;
                    end else begin
                        state_d.inst_cnt = bump(state_q.inst_cnt);
                    end
                end
            end
            brownout_pkg::INST_MONITOR: begin
                if (!sup.inst_above_100)
                    state_d.saw_above_100 = 1'b0;
                if (!sup.inst_above_110)
                    state_d.saw_above_110 = 1'b0;
                // Verdict includes this cycle, taken before the flags reseed
                win_100 = state_d.saw_above_100;
                win_110 = state_d.saw_above_110;
                if (sup.inst_below_095 && state_q.inst_steps < `INST_MAX_STEPS) begin
                    state_d.inst_steps = state_q.inst_steps + 2'h1;
                    state_d.inst_state = brownout_pkg::INST_STAB;
                    state_d.inst_cnt   = 24'h000000;
                end else if (state_q.tick) begin
                    if (state_q.inst_cnt == 24'(STAB_TICKS - 1)) begin
                        state_d.inst_cnt      = 24'h000000;
                        state_d.saw_above_100 = 1'b1;
                        state_d.saw_above_110 = 1'b1;
                        if (win_110) begin
                            state_d.inst_steps = 2'h0;
                            state_d.inst_state = brownout_pkg::INST_IDLE;
                        end else if (win_100 && state_q.inst_steps == 2'h2) begin
                            state_d.inst_steps = 2'h1;
                        end
                    end else begin
                        state_d.inst_cnt = bump(state_q.inst_cnt);
                    end
                end
            end
            default: begin
                state_d.inst_state = brownout_pkg::INST_IDLE;
                state_d.inst_steps = 2'h0;
            end
        endcase

        // =============================================================
        // Average path
        if (sup.avg_above_110 && state_q.mute) begin
            // Unmute first, restoration waits a full step period
            state_d.mute    = 1'b0;
            state_d.avg_cnt = 24'h000000;
        end else if (sup.avg_below_095 || (sup.avg_above_110 && state_q.avg_steps != 5'h00)) begin
            if (state_q.tick) begin
                if (state_q.avg_cnt == 24'(AVG_TICKS - 1)) begin
                    state_d.avg_cnt = 24'h000000;
                    if (sup.avg_below_095 && state_q.avg_steps < `AVG_MAX_STEPS) begin
                        state_d.avg_steps = state_q.avg_steps + `AVG_STEP_DB;
                        if (state_d.avg_steps == `AVG_MAX_STEPS)
                            state_d.mute = 1'b1;
                    end else if (sup.avg_above_110) begin
                        state_d.avg_steps = state_q.avg_steps - `AVG_STEP_DB;
                    end
                end else begin
                    state_d.avg_cnt = bump(state_q.avg_cnt);
                end
            end
        end else begin
            state_d.avg_cnt = 24'h000000;
        end

        // =============================================================
        // Low-battery notification, only cleared by shutdown reset
        if (!state_q.notify_active) begin
            if (notify_enable && sup.low_batt) begin
                state_d.notify_active = 1'b1;
                state_d.req           = 1'b1;
                state_d.notify_cnt    = 24'h000000;
            end
        end else if (state_q.tick) begin
            if (state_q.notify_cnt == 24'(NOTIFY_TICKS - 1)) begin
                state_d.notify_cnt = 24'h000000;
                state_d.req        = 1'b1;
            end else begin
                state_d.notify_cnt = bump(state_q.notify_cnt);
            end
        end

        // =============================================================
        // Outputs
        state_d.gain.inst_atten_db  = (state_d.inst_steps == 2'h2) ? 4'h6
                                    : (state_d.inst_steps == 2'h1) ? `INST_STEP_DB : 4'h0;
        state_d.gain.avg_atten_db   = state_d.avg_steps;
        state_d.gain.total_atten_db = {2'h0, state_d.gain.inst_atten_db}
                                    + {1'h0, state_d.avg_steps};
        state_d.gain.mute           = state_d.mute;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign gain_out     = state_q.gain;
    assign start_memory = state_q.memory;
    assign low_batt_req = state_q.req;

endmodule

// [brownout_gain_manager_sva.sv]
// Checker for the brownout gain manager outputs
`timescale 1ns/1ps
module brownout_gain_manager_sva (
    input wire logic                     clock,
    input wire logic                     sys_rst,
    input wire brownout_pkg::supply_type supply_in,
    input wire logic                     deep_drop,
    input wire logic [1:0]               prior_memory,
    input wire logic                     notify_enable,
    input wire brownout_pkg::gain_type   gain_out,
    input wire logic [1:0]               start_memory,
    input wire logic                     low_batt_req
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    total_is_sum_a: assert property (gain_out.total_atten_db ==
        gain_out.inst_atten_db + gain_out.avg_atten_db) else $error("total is not the sum");
    inst_limit_a: assert property (gain_out.inst_atten_db inside {4'h0, 4'h3, 4'h6})
        else $error("instantaneous reduction out of range");
    avg_limit_a: assert property (gain_out.avg_atten_db <= 5'h12)
        else $error("average reduction above limit");
    mute_at_max_a: assert property ($rose(gain_out.mute) |-> gain_out.avg_atten_db == 5'h12)
        else $error("mute without full average reduction");
    inst_step_a: assert property (gain_out.inst_atten_db > $past(gain_out.inst_atten_db)
        |-> gain_out.inst_atten_db == $past(gain_out.inst_atten_db) + 4'h3)
        else $error("instantaneous step not 3 dB");
    avg_step_a: assert property ($changed(gain_out.avg_atten_db) |->
        gain_out.avg_atten_db == $past(gain_out.avg_atten_db) + 5'h01 ||
        gain_out.avg_atten_db == $past(gain_out.avg_atten_db) - 5'h01)
        else $error("average step not 1 dB");
    avg_hold_a: assert property ((!supply_in.avg_below_095 && !supply_in.avg_above_110) [*5]
        |=> $stable(gain_out.avg_atten_db)) else $error("average count moved in dead band");
    unmute_first_a: assert property (gain_out.avg_atten_db < $past(gain_out.avg_atten_db)
        |-> !$past(gain_out.mute)) else $error("gain restored while muted");
    dip_react_a: assert property ($rose(supply_in.inst_below_095) &&
        !supply_in.avg_below_095 && gain_out.inst_atten_db == 4'h0
        |-> ##[1:4] gain_out.inst_atten_db == 4'h3) else $error("dip not answered");
    req_spacing_a: assert property (low_batt_req |=> !low_batt_req [*5])
        else $error("indicator requests too close");
endmodule
bind brownout_gain_manager brownout_gain_manager_sva brownout_gain_manager_sva_i (.clock,
    .sys_rst, .supply_in, .deep_drop, .prior_memory, .notify_enable, .gain_out,
    .start_memory, .low_batt_req);

// [supply_monitor_model.sv]
// Comparator model of the supply monitor, driven by millivolt levels
`timescale 1ns/1ps
module supply_monitor_model (
    // Levels in millivolts
    input  int                       inst_mv,
    input  int                       avg_mv,
    input  wire logic                batt_low,
    // Comparator results
    output brownout_pkg::supply_type supply
);
    // Strict compares: a level exactly on a threshold reads as neither side
    always_comb begin
        supply.inst_below_095 = inst_mv < 950;
        supply.inst_above_100 = inst_mv > 1000;
        supply.inst_above_110 = inst_mv > 1100;
        supply.avg_below_095  = avg_mv < 950;
        supply.avg_above_110  = avg_mv > 1100;
        supply.low_batt       = batt_low;
    end
endmodule

// [brownout_gain_manager_tb_top.sv]
// Self-checking testbench for the brownout gain manager
`timescale 1ns/1ps
module brownout_gain_manager_tb_top;
    logic clock, sys_rst, batt_low, deep_drop, notify_enable, low_batt_req;
    logic [1:0] prior_memory, start_memory;
    int inst_mv, avg_mv, num_errors, checks_done;
    brownout_pkg::supply_type supply;
    brownout_pkg::gain_type gain_out;
    supply_monitor_model supply_monitor_model_i (.inst_mv(inst_mv), .avg_mv(avg_mv),
        .batt_low(batt_low), .supply(supply));
    // Short counts: tick of 4 clocks, 5/3/6 ticks
    brownout_gain_manager #(.TICK_DIV(4), .STAB_TICKS(5), .AVG_TICKS(3), .NOTIFY_TICKS(6))
    brownout_gain_manager_i (.clock(clock), .sys_rst(sys_rst), .supply_in(supply),
        .deep_drop(deep_drop), .prior_memory(prior_memory), .notify_enable(notify_enable),
        .gain_out(gain_out), .start_memory(start_memory), .low_batt_req(low_batt_req));
    always #5 clock = ~clock;
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [5:0] field(input int sel);
        case (sel)
            0: return gain_out.inst_atten_db;
            1: return gain_out.avg_atten_db;
            default: return gain_out.mute;
        endcase
    endfunction
    // Bounded poll; a run-out ends the run
    task automatic wait_for(input int sel, input logic [5:0] v);
        int n;
        for (n = 0; n < 400 && field(sel) !== v; n++) @(negedge clock);
        check(field(sel), v);
        if (n == 400) wrap_up();
    endtask
    task automatic inst_steps();
        @(negedge clock) inst_mv = 900;
        wait_for(0, 6'h03);
        repeat (10) @(negedge clock);
        check(gain_out.inst_atten_db, 16'h0003);
        wait_for(0, 6'h06);
        repeat (120) @(negedge clock);
        check(gain_out.inst_atten_db, 16'h0006);
        check(gain_out.avg_atten_db, 16'h0000);
        inst_mv = 1050;
        wait_for(0, 6'h03);
        inst_mv = 1200;
        wait_for(0, 6'h00);
        $display("inst_steps done");
    endtask
    task automatic avg_steps();
        @(negedge clock) avg_mv = 900;
        wait_for(2, 6'h01);
        check(gain_out.avg_atten_db, 16'h0012);
        check(gain_out.total_atten_db, 16'h0012);
        avg_mv = 1000;
        repeat (60) @(negedge clock);
        check({gain_out.avg_atten_db, gain_out.mute}, 16'h0025);
        avg_mv = 1200;
        wait_for(2, 6'h00);
        check(gain_out.avg_atten_db, 16'h0012);
        wait_for(1, 6'h00);
        $display("avg_steps done");
    endtask
    task automatic notify_test();
        logic [15:0] pulses;
        pulses = 16'h0000;
        @(negedge clock) batt_low = 1'h1;
        repeat (40) @(negedge clock) pulses += low_batt_req;
        check(pulses, 16'h0000);
        notify_enable = 1'h1;
        repeat (90) @(negedge clock) pulses += low_batt_req;
        check(pulses, 16'h0004);
        $display("notify_test done");
    endtask
    task automatic restart_test();
        for (int i = 0; i < 2; i++) begin
            inst_mv = 900;
            wait_for(0, 6'h03);
            deep_drop = (i == 0);
            prior_memory = 2'h2;
            sys_rst = 1'h1;
            repeat (3) @(negedge clock);
            sys_rst = 1'h0;
            inst_mv = 1200;
            repeat (3) @(negedge clock);
            check(start_memory, (i == 0) ? 16'h0000 : 16'h0002);
            check(gain_out, 16'h0000);
        end
        $display("restart_test done");
    endtask
    initial begin
        {clock, batt_low, deep_drop, notify_enable, prior_memory} = 6'h00;
        inst_mv     = 1200;
        avg_mv      = 1200;
        num_errors  = 0;
        checks_done = 0;
        sys_rst = 1'h1;
        repeat (3) @(negedge clock);
        sys_rst = 1'h0;
        repeat (3) @(negedge clock);
        inst_steps();
        avg_steps();
        notify_test();
        restart_test();
        wrap_up();
    end
endmodule
